//--- hw/sds_defines.svh
// constants for the step/dir microstep sequencer: offsets, fields, resets
// assumes inclusion by bare name from every design file that needs them
`ifndef SDS_DEFINES_SVH
`define SDS_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets (word index)
// ---------------------------------------------------------------
`define SDS_ADDR_GLOBAL_CFG   4'h0
`define SDS_ADDR_CHOP_CFG     4'h1
`define SDS_ADDR_CURRENT      4'h2
`define SDS_ADDR_STATUS       4'h3

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define SDS_GCFG_FASTSTST_BIT 0
`define SDS_GCFG_EXTSTEP_BIT  1
`define SDS_CHOP_MRES_LSB     0
`define SDS_CHOP_INTPOL_BIT   4
`define SDS_CHOP_DEDGE_BIT    5
`define SDS_CUR_HOLD_LSB      0
`define SDS_CUR_RUN_LSB       8
`define SDS_STAT_STST_BIT     0
`define SDS_STAT_MSCNT_LSB    16

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define SDS_GCFG_RST          2'h2
`define SDS_MRES_RST          4'h0
`define SDS_HOLD_RST          5'h08
`define SDS_RUN_RST           5'h10
`define SDS_MSCNT_RST         10'h000
`define SDS_MRES_MAX          4'h8
`define SDS_PERIOD_MAX        20'hF_FFFF
`define SDS_STST_LONG_CYC     (1 << 20)
`define SDS_STST_SHORT_CYC    (1 << 18)
`define SDS_SINE_CORR         18'h0_003A

`endif

//--- hw/sds_pkg.sv
// types shared by the step/dir microstep sequencer modules
// assumes nothing beyond a SystemVerilog compiler
package sds_pkg;
  typedef logic [9:0]        sds_pos_t;
  typedef logic [3:0]        sds_mres_t;
  typedef logic signed [9:0] sds_coil_t;
  typedef logic [19:0]       sds_period_t;
  typedef enum logic {SDS_IP_IDLE, SDS_IP_RUN} sds_ip_state_e;
endpackage : sds_pkg

//--- hw/sds_ustep_if.sv
// link between the sequencer core and its step interpolator
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface sds_ustep_if
  import sds_pkg::*;
  ();
  logic        step_evt;
  sds_mres_t   mres;
  sds_period_t period;
  logic        enable;
  logic        fine;
  modport seq    (output step_evt, mres, period, enable, input fine);
  modport interp (input step_evt, mres, period, enable, output fine);
endinterface : sds_ustep_if
`default_nettype wire

//--- hw/sds_sine_rom.sv
// sine/cosine coil current lookup with registered read data
// assumes a 10-bit table index and one clock
`timescale 1ns/1ns
`default_nettype none
`include "sds_defines.svh"
module sds_sine_rom
  import sds_pkg::*;
  (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire sds_pos_t i_pos,
  output var  sds_coil_t o_sin,
  output var  sds_coil_t o_cos
  );

  sds_coil_t sin_d;
  sds_coil_t cos_d;

  // ---------------------------------------------------------------
  // table entry: corrected parabola per quarter wave
  // ---------------------------------------------------------------
  function automatic sds_coil_t sds_sine(input sds_pos_t pos);
    logic [8:0]  x;
    logic [17:0] par;
    logic [8:0]  s;
    logic [17:0] sq;
    logic [17:0] corr;
    logic [8:0]  mag;
    x    = pos[8] ? (9'h100 - {1'b0, pos[7:0]}) : {1'b0, pos[7:0]};
    par  = 18'(x) * (18'h0_0200 - 18'(x));
    s    = 9'(par >> 8);
    sq   = (18'(s) * 18'(s)) >> 8;
    corr = (`SDS_SINE_CORR * (18'(s) - sq)) >> 8;
    mag  = s - 9'(corr);
    sds_sine = pos[9] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
  endfunction : sds_sine

  always_comb begin
    sin_d = sds_sine(i_pos);
    cos_d = sds_sine(i_pos + 10'h100);
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_sin <= '0;
      o_cos <= '0;
    end else begin
      o_sin <= sin_d;
      o_cos <= cos_d;
    end
  end
endmodule : sds_sine_rom
`default_nettype wire

//--- hw/sds_interp.sv
// step interpolator: fine microstep pulses spread over last step period
// assumes step events and period come from the sequencer core
`timescale 1ns/1ns
`default_nettype none
`include "sds_defines.svh"
module sds_interp
  import sds_pkg::*;
  (
  input  wire logic  i_clk,
  input  wire logic  i_reset,
  sds_ustep_if.interp u_step
  );

  sds_ip_state_e state_q, state_d;
  logic [8:0]    remain_q, remain_d;
  sds_period_t   interval_q, interval_d;
  sds_period_t   tick_q, tick_d;
  sds_period_t   shifted;

  assign u_step.fine = (state_q == SDS_IP_RUN) && (tick_q == '0);

  always_comb begin
    state_d    = state_q;
    remain_d   = remain_q;
    interval_d = interval_q;
    tick_d     = tick_q;
    shifted    = u_step.period >> u_step.mres;
    if (!u_step.enable) begin
      state_d  = SDS_IP_IDLE;
      remain_d = '0;
    end else if (u_step.step_evt) begin
      remain_d   = 9'h001 << u_step.mres;
      interval_d = (shifted == '0) ? 20'h0_0001 : shifted;
      tick_d     = '0;
      state_d    = SDS_IP_RUN;
    end else begin
      unique case (state_q)
        SDS_IP_IDLE: begin
          tick_d = '0;
        end
        SDS_IP_RUN: begin
          if (tick_q == interval_q - 20'h0_0001) begin
            tick_d = '0;
          end else begin
            tick_d = tick_q + 20'h0_0001;
          end
          if (tick_q == '0) begin
            remain_d = remain_q - 9'h001;
            if (remain_q == 9'h001) begin
              state_d = SDS_IP_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q    <= SDS_IP_IDLE;
      remain_q   <= '0;
      interval_q <= 20'h0_0001;
      tick_q     <= '0;
    end else begin
      state_q    <= state_d;
      remain_q   <= remain_d;
      interval_q <= interval_d;
      tick_q     <= tick_d;
    end
  end
endmodule : sds_interp
`default_nettype wire

//--- hw/sds_step_dir_seq.sv
// step/dir front end: sync, microstep counter, interpolation, standstill
// assumes a register master with one-cycle strobes and one system clock
`timescale 1ns/1ns
`default_nettype none
`include "sds_defines.svh"
module sds_step_dir_seq
  import sds_pkg::*;
  #(
  parameter int unsigned STST_LONG_CYC  = `SDS_STST_LONG_CYC,
  parameter int unsigned STST_SHORT_CYC = `SDS_STST_SHORT_CYC
  )
  (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_step,
  input  wire logic        i_dir,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output sds_coil_t        o_coil_a,
  output sds_coil_t        o_coil_b,
  output sds_pos_t         o_mscnt,
  output logic             o_standstill,
  output logic      [4:0]  o_current_scale,
  output logic             o_ramp_disable
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic sds_pos_t sds_width(input sds_mres_t mres);
    sds_width = 10'h001 << mres;
  endfunction : sds_width

  function automatic sds_pos_t sds_norm(input sds_pos_t pos,
                                        input sds_mres_t mres);
    sds_pos_t w;
    w = sds_width(mres);
    if (mres == '0) begin
      sds_norm = pos;
    end else begin
      sds_norm = (pos & ~(w - 10'h001)) | (w >> 1);
    end
  endfunction : sds_norm

  function automatic logic sds_sel(input logic [3:0] addr,
                                   input logic [3:0] target);
    sds_sel = (addr == target);
  endfunction : sds_sel

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [1:0]  gcfg_q, gcfg_d;
  sds_mres_t   mres_q, mres_d;
  logic        intpol_q, intpol_d;
  logic        dedge_q, dedge_d;
  logic [4:0]  hold_q, hold_d;
  logic [4:0]  run_q, run_d;
  logic [31:0] rdata_q, rdata_d;

  logic        step_s1_q, step_s2_q, step_s3_q;
  logic        dir_s1_q, dir_s2_q;
  logic        step_evt;

  sds_pos_t    cnt_q, cnt_d;
  sds_pos_t    target_q, target_d;
  logic        dir_q, dir_d;
  sds_pos_t    width;

  logic [20:0] idle_q, idle_d;
  logic        stst_q, stst_d;
  sds_period_t period_q, period_d;
  logic [4:0]  cur_q, cur_d;
  logic [20:0] thr;

  sds_mres_t   wr_mres;

  sds_ustep_if u_if ();

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  always_comb begin
    gcfg_d   = gcfg_q;
    mres_d   = mres_q;
    intpol_d = intpol_q;
    dedge_d  = dedge_q;
    hold_d   = hold_q;
    run_d    = run_q;
    rdata_d  = '0;
    wr_mres  = i_wdata[`SDS_CHOP_MRES_LSB +: 4];
    if (i_wr && sds_sel(i_addr, `SDS_ADDR_GLOBAL_CFG)) begin
      gcfg_d = i_wdata[1:0];
    end
    if (i_wr && sds_sel(i_addr, `SDS_ADDR_CHOP_CFG)) begin
      mres_d   = (wr_mres > `SDS_MRES_MAX) ? `SDS_MRES_MAX : wr_mres;
      intpol_d = i_wdata[`SDS_CHOP_INTPOL_BIT];
      dedge_d  = i_wdata[`SDS_CHOP_DEDGE_BIT];
    end
    if (i_wr && sds_sel(i_addr, `SDS_ADDR_CURRENT)) begin
      hold_d = i_wdata[`SDS_CUR_HOLD_LSB +: 5];
      run_d  = i_wdata[`SDS_CUR_RUN_LSB +: 5];
    end
    if (i_rd) begin
      if (sds_sel(i_addr, `SDS_ADDR_GLOBAL_CFG)) begin
        rdata_d[1:0] = gcfg_q;
      end
      if (sds_sel(i_addr, `SDS_ADDR_CHOP_CFG)) begin
        rdata_d[`SDS_CHOP_MRES_LSB +: 4]  = mres_q;
        rdata_d[`SDS_CHOP_INTPOL_BIT]     = intpol_q;
        rdata_d[`SDS_CHOP_DEDGE_BIT]      = dedge_q;
      end
      if (sds_sel(i_addr, `SDS_ADDR_CURRENT)) begin
        rdata_d[`SDS_CUR_HOLD_LSB +: 5] = hold_q;
        rdata_d[`SDS_CUR_RUN_LSB +: 5]  = run_q;
      end
      if (sds_sel(i_addr, `SDS_ADDR_STATUS)) begin
        rdata_d[`SDS_STAT_STST_BIT]       = stst_q;
        rdata_d[`SDS_STAT_MSCNT_LSB +: 10] = cnt_q;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      gcfg_q   <= `SDS_GCFG_RST;
      mres_q   <= `SDS_MRES_RST;
      intpol_q <= 1'b0;
      dedge_q  <= 1'b0;
      hold_q   <= `SDS_HOLD_RST;
      run_q    <= `SDS_RUN_RST;
      rdata_q  <= '0;
    end else begin
      gcfg_q   <= gcfg_d;
      mres_q   <= mres_d;
      intpol_q <= intpol_d;
      dedge_q  <= dedge_d;
      hold_q   <= hold_d;
      run_q    <= run_d;
      rdata_q  <= rdata_d;
    end
  end

  assign o_rdata        = rdata_q;
  assign o_ramp_disable = gcfg_q[`SDS_GCFG_EXTSTEP_BIT];

  // ---------------------------------------------------------------
  // input synchroniser and edge detect
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      step_s1_q <= 1'b0;
      step_s2_q <= 1'b0;
      step_s3_q <= 1'b0;
      dir_s1_q  <= 1'b0;
      dir_s2_q  <= 1'b0;
    end else begin
      step_s1_q <= i_step;
      step_s2_q <= step_s1_q;
      step_s3_q <= step_s2_q;
      dir_s1_q  <= i_dir;
      dir_s2_q  <= dir_s1_q;
    end
  end

  assign step_evt = dedge_q ? (step_s2_q ^ step_s3_q)
                            : (step_s2_q & ~step_s3_q);

  // ---------------------------------------------------------------
  // microstep counter
  // ---------------------------------------------------------------
  assign u_if.step_evt = step_evt;
  assign u_if.mres     = mres_q;
  assign u_if.period   = period_d;
  assign u_if.enable   = intpol_q;

  always_comb begin
    cnt_d    = cnt_q;
    target_d = target_q;
    dir_d    = dir_q;
    width    = sds_width(mres_q);
    if (intpol_q) begin
      if (step_evt) begin
        dir_d    = dir_s2_q;
        cnt_d    = target_q;
        target_d = sds_norm(dir_s2_q ? target_q - width
                                     : target_q + width, mres_q);
      end else if (u_if.fine) begin
        cnt_d = dir_q ? cnt_q - 10'h001 : cnt_q + 10'h001;
      end
    end else begin
      if (step_evt) begin
        dir_d = dir_s2_q;
        cnt_d = sds_norm(dir_s2_q ? cnt_q - width
                                  : cnt_q + width, mres_q);
      end else begin
        cnt_d = sds_norm(cnt_q, mres_q);
      end
      target_d = cnt_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cnt_q    <= `SDS_MSCNT_RST;
      target_q <= `SDS_MSCNT_RST;
      dir_q    <= 1'b0;
    end else begin
      cnt_q    <= cnt_d;
      target_q <= target_d;
      dir_q    <= dir_d;
    end
  end

  assign o_mscnt = cnt_q;

  // ---------------------------------------------------------------
  // standstill, step period and current select
  // ---------------------------------------------------------------
  always_comb begin
    thr = gcfg_q[`SDS_GCFG_FASTSTST_BIT] ? 21'(STST_SHORT_CYC)
                                         : 21'(STST_LONG_CYC);
    if (step_evt) begin
      idle_d = '0;
    end else if (idle_q >= thr) begin
      idle_d = idle_q;
    end else begin
      idle_d = idle_q + 21'h00_0001;
    end
    if (step_evt && (idle_q != thr - 21'h00_0001)) begin
      stst_d = 1'b0;
    end else if (idle_q >= thr - 21'h00_0001) begin
      stst_d = 1'b1;
    end else begin
      stst_d = stst_q;
    end
    period_d = period_q;
    if (step_evt) begin
      period_d = (idle_q >= 21'(`SDS_PERIOD_MAX)) ? `SDS_PERIOD_MAX
                                                   : 20'(idle_q + 21'h00_0001);
    end
    cur_d = stst_d ? hold_q : run_q;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      idle_q   <= '0;
      stst_q   <= 1'b0;
      period_q <= `SDS_PERIOD_MAX;
      cur_q    <= `SDS_RUN_RST;
    end else begin
      idle_q   <= idle_d;
      stst_q   <= stst_d;
      period_q <= period_d;
      cur_q    <= cur_d;
    end
  end

  assign o_standstill    = stst_q;
  assign o_current_scale = cur_q;

  // ---------------------------------------------------------------
  // sub-blocks
  // ---------------------------------------------------------------
  sds_interp u_interp (
    .i_clk  (i_clk),
    .i_reset(i_reset),
    .u_step (u_if.interp)
  );

  sds_sine_rom u_rom (
    .i_clk  (i_clk),
    .i_reset(i_reset),
    .i_pos  (cnt_q),
    .o_sin  (o_coil_a),
    .o_cos  (o_coil_b)
  );
endmodule : sds_step_dir_seq
`default_nettype wire

//--- sim/sds_step_dir_seq_chk.sv
// checker: port timing of the step/dir sequencer top
// assumes bind onto sds_step_dir_seq, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
module sds_step_dir_seq_chk
  import sds_pkg::*;
  #(
  parameter int unsigned STST_LONG_CYC  = 64,
  parameter int unsigned STST_SHORT_CYC = 16
  )
  (
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_step,
  input wire logic        i_dir,
  input wire logic [3:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire sds_coil_t   o_coil_a,
  input wire sds_coil_t   o_coil_b,
  input wire sds_pos_t    o_mscnt,
  input wire logic        o_standstill,
  input wire logic [4:0]  o_current_scale,
  input wire logic        o_ramp_disable
  );
  // ----
  // shadow state
  // ----
  logic [2:0]  stp_q;
  logic [1:0]  dir_q;
  logic [5:0]  chop_q;
  logic [1:0]  gcfg_q;
  logic [12:0] cur_q;
  logic        wc_q;
  logic        wi_q;
  logic [19:0] idle_q;
  logic        evt;
  logic        diag;
  logic [1:0]  qd;
  sds_pos_t    w;
  sds_pos_t    exp_cnt;
  sds_coil_t   mag;
  int unsigned thr;
  assign evt = (stp_q[1] & ~stp_q[2]) | (chop_q[5] & ~stp_q[1] & stp_q[2]);
  assign w = 10'h001 << chop_q[3:0];
  assign exp_cnt = dir_q[1] ? o_mscnt - w : o_mscnt + w;
  assign diag = o_mscnt[7:0] == 8'h80;
  assign qd = {o_mscnt[9], o_mscnt[9] ^ o_mscnt[8]};
  assign mag = o_coil_a[9] ? -o_coil_a : o_coil_a;
  assign thr = gcfg_q[0] ? STST_SHORT_CYC : STST_LONG_CYC;
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      stp_q  <= 3'h0;
      dir_q  <= 2'h0;
      chop_q <= 6'h00;
      gcfg_q <= 2'h2;
      cur_q  <= 13'h1008;
      wc_q   <= 1'b0;
      wi_q   <= 1'b0;
      idle_q <= 20'h0_0000;
    end else begin
      stp_q <= {stp_q[1:0], i_step};
      dir_q <= {dir_q[0], i_dir};
      wc_q  <= i_wr && i_addr == 4'h1;
      wi_q  <= i_wr && i_addr == 4'h2;
      idle_q <= evt ? 20'h0_0000 : idle_q + 20'(idle_q != 20'hF_FFFF);
      if (i_wr && i_addr == 4'h0) gcfg_q <= i_wdata[1:0];
      if (i_wr && i_addr == 4'h1) chop_q <= {i_wdata[5:4],
          (i_wdata[3:0] > 4'h8) ? 4'h8 : i_wdata[3:0]};
      if (i_wr && i_addr == 4'h2) cur_q <= {i_wdata[12:8], 3'h0, i_wdata[4:0]};
    end
  end
  // ----
  // assertions
  // ----
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);
  sequence s_plain;
    !chop_q[4] && !wc_q;
  endsequence
  sequence s_step_seen;
    s_plain ##0 evt;
  endsequence
  a_rd_idle_zero: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside read");
  a_stat_read: assert property (i_rd && i_addr == 4'h3 |=>
    o_rdata[0] == $past(o_standstill) && o_rdata[25:16] == $past(o_mscnt))
    else $error("status read wrong");
  a_step_move: assert property (s_step_seen |=> o_mscnt == $past(exp_cnt))
    else $error("step did not move counter by width");
  a_mscnt_hold: assert property (s_plain ##0 !evt |=> $stable(o_mscnt))
    else $error("counter moved without step");
  a_grid_snap: assert property (s_plain |-> (o_mscnt & (w - 10'h001)) == (w >> 1))
    else $error("counter off resolution grid");
  a_coil_quad: assert property ($past(diag) |-> {o_coil_a[9], o_coil_b[9]} == $past(qd) && mag >= 10'sd176 && mag <= 10'sd186 && (o_coil_b == o_coil_a || o_coil_b == -o_coil_a))
    else $error("full step coil current wrong");
  a_stst_rise: assert property ($rose(o_standstill) |-> idle_q == thr)
    else $error("standstill set at wrong time");
  a_stst_clear: assert property (o_standstill && evt |=> !o_standstill)
    else $error("standstill not cleared by step");
  a_cur_select: assert property (!wi_q |-> o_current_scale == (o_standstill ? cur_q[4:0] : cur_q[12:8]))
    else $error("current scale wrong");
  a_ramp_ext: assert property (o_ramp_disable == gcfg_q[1])
    else $error("ramp disable wrong");
endmodule : sds_step_dir_seq_chk
`default_nettype wire

//--- sim/sds_step_src.sv
// external motion controller model: one step pulse per request
// assumes one clock; dir settles four cycles before the step edge
`timescale 1ns/1ns
`default_nettype none
module sds_step_src
  (
  input  wire logic        i_clk,
  input  wire logic        i_go,
  input  wire logic        i_dir_req,
  input  wire logic [15:0] i_half,
  output logic             o_step,
  output logic             o_dir,
  output logic             o_busy
  );
  logic [17:0] cnt_q;
  logic [17:0] hi;
  assign hi = (i_half < 16'h0002) ? 18'h0_0002 : {2'h0, i_half};
  initial begin
    o_step = 1'b0;
    o_dir  = 1'b0;
    o_busy = 1'b0;
    cnt_q  = 18'h0_0000;
  end
  always @(posedge i_clk) begin
    if (i_go && !o_busy) begin
      o_dir  <= i_dir_req;
      o_busy <= 1'b1;
      cnt_q  <= 18'h0_0000;
    end else if (o_busy) begin
      cnt_q <= cnt_q + 18'h0_0001;
      if (cnt_q == 18'h0_0003) o_step <= 1'b1;
      if (cnt_q == 18'h0_0003 + hi) o_step <= 1'b0;
      if (cnt_q == 18'h0_0003 + 2 * hi) o_busy <= 1'b0;
    end
  end
endmodule : sds_step_src
`default_nettype wire

//--- sim/tb_sds_step_dir_seq.sv
// testbench: register bus, step table, standstill, interpolation, reset
// assumes the step source model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_total++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module tb_sds_step_dir_seq;
  import sds_pkg::*;
  typedef struct packed {logic [3:0] mres; logic dedge; logic dir;
    logic [1:0] n; sds_pos_t pos;} sds_row_s;
  logic        i_clk, i_reset, i_wr, i_rd, go, dirq, i_step, i_dir, busy;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata, d;
  logic [15:0] half;
  logic [31:0] o_rdata;
  sds_coil_t   o_coil_a, o_coil_b;
  sds_pos_t    o_mscnt, prev;
  logic        o_standstill, o_ramp_disable;
  logic [4:0]  o_current_scale;
  int          err_total, checked, ch;
  sds_row_s rows [11] = '{'{4'h8,0,0,2,10'h280}, '{4'h8,1,1,1,10'h080},
    '{4'h7,0,1,3,10'h340}, '{4'h6,0,0,1,10'h3A0}, '{4'h5,1,0,2,10'h030},
    '{4'h4,0,1,1,10'h028}, '{4'h3,0,1,2,10'h01C}, '{4'h2,0,0,1,10'h022},
    '{4'h1,0,0,1,10'h025}, '{4'h0,1,1,1,10'h023}, '{4'hF,0,0,1,10'h180}};
  sds_step_dir_seq #(.STST_LONG_CYC(64), .STST_SHORT_CYC(16)) dut_u (
    .i_clk(i_clk), .i_reset(i_reset), .i_step(i_step), .i_dir(i_dir),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_coil_a(o_coil_a), .o_coil_b(o_coil_b),
    .o_mscnt(o_mscnt), .o_standstill(o_standstill),
    .o_current_scale(o_current_scale), .o_ramp_disable(o_ramp_disable));
  sds_step_src u_src (.i_clk(i_clk), .i_go(go), .i_dir_req(dirq),
    .i_half(half), .o_step(i_step), .o_dir(i_dir), .o_busy(busy));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic complete_run();
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge i_clk); i_wr <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_clk); i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge i_clk); i_rd <= 1'b1; i_addr <= a;
    @(posedge i_clk); i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  task automatic kick(input logic dr, input logic [15:0] h);
    @(posedge i_clk); go <= 1'b1; dirq <= dr; half <= h;
    @(posedge i_clk); go <= 1'b0;
  endtask : kick
  task automatic pulse(input logic dr, input logic [15:0] h);
    int k;
    kick(dr, h);
    k = 0;
    #1 while (busy !== 1'b0 && k < 500) begin @(posedge i_clk); #1 k++; end
    if (k >= 500) begin err_total++; complete_run(); end
  endtask : pulse
  task automatic stst_run(input int ex);
    int n;
    kick(1'b0, 16'h0002);
    n = 0;
    #1 while ((n < 8 || o_standstill !== 1'b1) && n < 300) begin
      @(posedge i_clk); #1 n++;
      if (n == 8) `CHK("scale_run", 5'h0C, o_current_scale)
      if (n == 8) `CHK("stst_clr", 1'b0, o_standstill)
    end
    `CHK("stst_time", ex, n)
    `CHK("scale_hold", 5'h05, o_current_scale)
    if (n >= 300) complete_run();
  endtask : stst_run
  initial begin
    i_reset = 1'b1; i_wr = 1'b0; i_rd = 1'b0; go = 1'b0; dirq = 1'b0;
    i_addr = 4'h0; i_wdata = 32'h0000_0000; half = 16'h0002;
    err_total = 0; checked = 0;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rows[i]) begin
      wr(4'h1, {26'h0, rows[i].dedge, 1'b0, rows[i].mres});
      repeat (3) @(posedge i_clk);
      for (int j = 0; j < rows[i].n; j++) pulse(rows[i].dir, 16'h0002);
      repeat (4) @(posedge i_clk);
      #1 `CHK("mscnt", rows[i].pos, o_mscnt)
      rd(4'h3, d);
      `CHK("stat_cnt", rows[i].pos, d[25:16])
    end
    wr(4'h0, 32'h0000_0003); wr(4'h2, 32'h0000_0C05); wr(4'h1, 32'h0000_0004);
    stst_run(23);
    `CHK("ramp_on", 1'b1, o_ramp_disable)
    wr(4'h0, 32'h0000_0000);
    stst_run(71);
    `CHK("ramp_off", 1'b0, o_ramp_disable)
    wr(4'h1, 32'h0000_0014);
    pulse(1'b0, 16'h0014); pulse(1'b0, 16'h0014);
    kick(1'b0, 16'h0014);
    ch = 0;
    #1 prev = o_mscnt;
    repeat (60) begin
      @(posedge i_clk); #1;
      if (o_mscnt !== prev) begin
        ch++;
        `CHK("fine_step", prev + 10'h001, o_mscnt)
      end
      prev = o_mscnt;
    end
    `CHK("fine_count", 16, ch)
    `CHK("interp_end", 10'h1D8, o_mscnt)
    @(posedge i_clk); i_reset <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    #1 `CHK("rst_scale", 5'h10, o_current_scale)
    `CHK("rst_ramp", 1'b1, o_ramp_disable)
    `CHK("rst_cnt", 10'h000, o_mscnt)
    `CHK("rst_stst", 1'b0, o_standstill)
    wr(4'h3, 32'hFFFF_FFFF); wr(4'h9, 32'h0000_0001);
    foreach (rows[i]) if (i < 5) begin
      rd(4'(i == 4 ? 9 : i), d);
      `CHK("reg_rst", (i == 0) ? 32'h2 : (i == 2) ? 32'h1008 : 32'h0, d)
    end
    complete_run();
  end
endmodule : tb_sds_step_dir_seq
bind sds_step_dir_seq sds_step_dir_seq_chk #(
  .STST_LONG_CYC(STST_LONG_CYC), .STST_SHORT_CYC(STST_SHORT_CYC)) u_chk (
  .i_clk(i_clk), .i_reset(i_reset), .i_step(i_step), .i_dir(i_dir),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_coil_a(o_coil_a), .o_coil_b(o_coil_b),
  .o_mscnt(o_mscnt), .o_standstill(o_standstill),
  .o_current_scale(o_current_scale), .o_ramp_disable(o_ramp_disable));
`default_nettype wire
